/* File: dv/acl_load_model.sv */
// Load model: LEDs on the panel, counts each move of an LED into red
`timescale 1ns/1ns
module acl_load_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Driven by the alarm block
  input wire acl_pkg::acl_colour_t [3:0] status_led,
  // Activations seen per channel
  output logic [3:0][7:0] red_entries
);
  acl_pkg::acl_colour_t [3:0] last;
  always_ff @(posedge clk) begin
    last <= status_led;
    for (int k = 0; k < 4; k++) begin
      if (!rstn) begin
        red_entries[k] <= 8'h00;
      end else if (status_led[k] == acl_pkg::ACL_COL_RED &&
                   last[k] != acl_pkg::ACL_COL_RED) begin
        red_entries[k] <= red_entries[k] + 8'h01;
      end
    end
  end
endmodule

/* File: dv/acl_top_assertions.sv */
// Port-level assertions for the alarm channel block
`timescale 1ns/1ns
module acl_top_assertions #(
  parameter int NCH = 4,
  parameter int unsigned TICK_CYCLES = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Inputs
  input wire logic [acl_pkg::NSRC-1:0][acl_pkg::VW-1:0] meas,
  input wire acl_pkg::acl_cfg_t [NCH-1:0] cfg,
  input wire acl_pkg::acl_colour_t default_colour,
  // Outputs
  input wire logic [NCH-1:0] relay_coil,
  input wire acl_pkg::acl_colour_t [NCH-1:0] status_led,
  input wire acl_pkg::acl_colour_t display_colour
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  acl_pkg::acl_cfg_t c;
  acl_pkg::acl_colour_t l;
  logic hi;
  logic hm;
  int yel;
  int red;
  int t;
  assign c = cfg[0];
  assign l = status_led[0];
  assign hi = $signed(meas[c.src]) >= $signed(c.set_h);
  assign hm = c.mode == acl_pkg::ACL_MODE_HIGH;
  assign t = int'(TICK_CYCLES);
  // Dwell counters, cheaper than long repetitions
  always_ff @(posedge clk) begin
    if (!rstn) begin
      yel <= 0;
      red <= 0;
    end else begin
      yel <= (l == acl_pkg::ACL_COL_YELLOW) ? yel + 1 : 0;
      red <= (l == acl_pkg::ACL_COL_RED) ? red + 1 : 0;
    end
  end
  property p_top;
    status_led[NCH-1] != acl_pkg::ACL_COL_OFF |->
      display_colour == cfg[NCH-1].colour;
  endproperty
  a_top: assert property (p_top)
    else $error("display not top colour");
  property p_dflt;
    $past(rstn) && status_led == '0 |-> display_colour == default_colour;
  endproperty
  a_dflt: assert property (p_dflt)
    else $error("display not default");
  property p_red_coil;
    l == acl_pkg::ACL_COL_RED |-> relay_coil[0] == c.energise;
  endproperty
  a_red_coil: assert property (p_red_coil)
    else $error("coil inactive while red");
  property p_calm_coil;
    $past(rstn) && l != acl_pkg::ACL_COL_RED |-> relay_coil[0] == !c.energise;
  endproperty
  a_calm_coil: assert property (p_calm_coil)
    else $error("coil active while not red");
  property p_fast_trip;
    (hm && c.trip_delay == 0 && c.pulse == 0 && hi) [*3] |=>
      l == acl_pkg::ACL_COL_RED;
  endproperty
  a_fast_trip: assert property (p_fast_trip)
    else $error("no trip at set point");
  property p_fast_clear;
    (hm && c.hyst == 0 && c.off_delay == 0 && !hi) [*3] |=>
      l == acl_pkg::ACL_COL_OFF;
  endproperty
  a_fast_clear: assert property (p_fast_clear)
    else $error("no clear below set point");
  property p_yel_first;
    hm && c.trip_delay != 0 && $past(l) == acl_pkg::ACL_COL_OFF &&
      l != acl_pkg::ACL_COL_OFF |-> l == acl_pkg::ACL_COL_YELLOW;
  endproperty
  a_yel_first: assert property (p_yel_first)
    else $error("delay not shown yellow");
  property p_on_span;
    hm && $past(l) == acl_pkg::ACL_COL_YELLOW && l == acl_pkg::ACL_COL_RED
      |-> yel > c.trip_delay * t && yel <= (c.trip_delay + 1) * t;
  endproperty
  a_on_span: assert property (p_on_span)
    else $error("on-delay length wrong");
  property p_pulse_span;
    $past(l) == acl_pkg::ACL_COL_RED && l != acl_pkg::ACL_COL_RED &&
      (l == acl_pkg::ACL_COL_YELLOW || c.mode[2:1] == 2'h3)
      |-> red > c.pulse * t && red <= (c.pulse + 1) * t;
  endproperty
  a_pulse_span: assert property (p_pulse_span)
    else $error("pulse length wrong");
endmodule

/* File: dv/tb.sv */
// Self-checking bench for the alarm channel block
`timescale 1ns/1ns
`define CHK(w, e, g) \
  comparisons++; \
  if ((g) !== (e)) begin \
    miscompares++; \
    $display("[FAIL] %s exp %0h got %0h", w, e, g); \
  end
module tb;
  // Short tick keeps delays to a few cycles
  localparam int TCK = 4;
  localparam acl_pkg::acl_colour_t c_off = acl_pkg::ACL_COL_OFF;
  localparam acl_pkg::acl_colour_t c_red = acl_pkg::ACL_COL_RED;
  localparam acl_pkg::acl_colour_t c_yel = acl_pkg::ACL_COL_YELLOW;
  localparam acl_pkg::acl_colour_t c_grn = acl_pkg::ACL_COL_GREEN;
  logic clk;
  logic rstn;
  logic [3:0][15:0] meas;
  acl_pkg::acl_cfg_t [3:0] cfg;
  acl_pkg::acl_colour_t default_colour;
  logic [3:0] relay_coil;
  acl_pkg::acl_colour_t [3:0] status_led;
  acl_pkg::acl_colour_t display_colour;
  logic [3:0][7:0] red_entries;
  int miscompares = 0;
  int comparisons = 0;
  acl_top #(.NCH(4), .TICK_CYCLES(TCK)) uut (
    .clk(clk), .rstn(rstn), .meas(meas), .cfg(cfg),
    .default_colour(default_colour), .relay_coil(relay_coil),
    .status_led(status_led), .display_colour(display_colour));
  acl_load_model load (.clk(clk), .rstn(rstn),
    .status_led(status_led), .red_entries(red_entries));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Config only changes under reset, so the checker needs no guards
  task automatic quiet();
    rstn = 1'b0;
    meas = '0;
    default_colour = c_grn;
    for (int k = 0; k < 4; k++) begin
      cfg[k] = '0;
      cfg[k].set_h = 16'h7FFF;
    end
  endtask
  task automatic restart();
    repeat (5) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
  endtask
  task automatic wait_led(int ch, acl_pkg::acl_colour_t col, int lim);
    for (int n = 0; n < lim && status_led[ch] !== col; n++) begin
      @(negedge clk);
    end
    `CHK("led wait", col, status_led[ch])
    if (status_led[ch] !== col) begin
      tally_and_finish();
    end
  endtask
  task automatic t_high();
    quiet();
    cfg[0].src = 2'h1;
    cfg[0].set_h = 16'h0064;
    cfg[0].trip_delay = 10'h002;
    cfg[0].off_delay = 10'h002;
    cfg[0].colour = c_red;
    restart();
    `CHK("idle led", c_off, status_led[0])
    `CHK("idle coil", 1'b1, relay_coil[0])
    `CHK("idle disp", c_grn, display_colour)
    meas[1] = 16'h0064;
    repeat (3) @(negedge clk);
    `CHK("wait led", c_yel, status_led[0])
    `CHK("wait disp", c_red, display_colour)
    meas[1] = 16'h0063;
    wait_led(0, c_off, 4);
    `CHK("glitch coil", 1'b1, relay_coil[0])
    meas[1] = 16'h0064;
    wait_led(0, c_red, 3 * TCK + 4);
    `CHK("trip coil", 1'b0, relay_coil[0])
    repeat (6 * TCK) @(negedge clk);
    `CHK("hold led", c_red, status_led[0])
    meas[1] = 16'h0063;
    repeat (4) @(negedge clk);
    `CHK("off wait", c_red, status_led[0])
    wait_led(0, c_off, 2 * TCK + 4);
    `CHK("rel coil", 1'b1, relay_coil[0])
    `CHK("rel disp", c_grn, display_colour)
    $display("t_high done");
  endtask
  task automatic t_hyst();
    quiet();
    cfg[0].set_h = 16'h0064;
    cfg[0].hyst = 16'h001E;
    cfg[0].energise = 1'b1;
    restart();
    meas[0] = 16'h0064;
    wait_led(0, c_red, 4);
    `CHK("hys coil", 1'b1, relay_coil[0])
    meas[0] = 16'h0046;
    repeat (4) @(negedge clk);
    `CHK("hys hold", c_red, status_led[0])
    meas[0] = 16'h0045;
    wait_led(0, c_off, 4);
    `CHK("hys coil", 1'b0, relay_coil[0])
    $display("t_hyst done");
  endtask
  task automatic t_prio();
    acl_pkg::acl_mode_t md [4] = '{acl_pkg::ACL_MODE_HIGH,
      acl_pkg::ACL_MODE_IN_BAND, acl_pkg::ACL_MODE_PUMP_LOW,
      acl_pkg::ACL_MODE_OUT_BAND};
    acl_pkg::acl_colour_t col [4] = '{c_red, c_yel, c_red, c_grn};
    logic [15:0] av [4] = '{16'h0020, 16'h0018, 16'h0010, 16'h0021};
    quiet();
    default_colour = c_off;
    meas[1] = 16'h0018;
    meas[0] = 16'h0018;
    for (int k = 0; k < 4; k++) begin
      cfg[k].mode = md[k];
      cfg[k].src = 2'(3 - k);
      cfg[k].set_l = 16'h0010;
      cfg[k].set_h = 16'h0020;
      cfg[k].colour = col[k];
    end
    restart();
    `CHK("calm disp", c_off, display_colour)
    for (int k = 0; k < 4; k++) begin
      meas[3 - k] = av[k];
      repeat (3) @(negedge clk);
      `CHK("chan led", c_red, status_led[k])
      `CHK("prio disp", col[k], display_colour)
    end
    `CHK("all coils", 4'h0, relay_coil)
    meas[0] = 16'h0018;
    repeat (3) @(negedge clk);
    `CHK("drop top", col[2], display_colour)
    $display("t_prio done");
  endtask
  task automatic t_cycle();
    quiet();
    cfg[0].set_h = 16'h0064;
    cfg[0].trip_delay = 10'h002;
    cfg[0].pulse = 10'h003;
    restart();
    meas[0] = 16'h0064;
    wait_led(0, c_red, 3 * TCK + 4);
    wait_led(0, c_yel, 4 * TCK + 4);
    `CHK("gap coil", 1'b1, relay_coil[0])
    wait_led(0, c_red, 3 * TCK + 4);
    `CHK("pulse coil", 1'b0, relay_coil[0])
    // Load model counts one edge behind the LED
    @(negedge clk);
    `CHK("pulse count", 8'h02, red_entries[0])
    meas[0] = 16'h0000;
    wait_led(0, c_off, 4);
    $display("t_cycle done");
  endtask
  task automatic t_shot();
    acl_pkg::acl_mode_t md [2] = '{acl_pkg::ACL_MODE_ONE_SHOT_HIGH,
      acl_pkg::ACL_MODE_ONE_SHOT_LOW};
    logic [15:0] av [2] = '{16'h0064, 16'h0063};
    logic [15:0] qv [2] = '{16'h0000, 16'h0064};
    for (int m = 0; m < 2; m++) begin
      quiet();
      cfg[0].mode = md[m];
      cfg[0].set_h = 16'h0064;
      cfg[0].trip_delay = 10'h001;
      cfg[0].pulse = 10'h002;
      meas[0] = qv[m];
      restart();
      meas[0] = av[m];
      repeat (2) @(negedge clk);
      `CHK("shot wait", c_off, status_led[0])
      wait_led(0, c_red, 2 * TCK + 4);
      wait_led(0, c_off, 3 * TCK + 4);
      repeat (8 * TCK) @(negedge clk);
      `CHK("shot led", c_off, status_led[0])
      `CHK("shot coil", 1'b1, relay_coil[0])
      `CHK("shot count", 8'h01, red_entries[0])
    end
    $display("t_shot done");
  endtask
  initial begin
    quiet();
    t_high();
    t_hyst();
    t_prio();
    t_cycle();
    t_shot();
    tally_and_finish();
  end
endmodule
bind acl_top acl_top_assertions #(.NCH(NCH), .TICK_CYCLES(TICK_CYCLES)) chk (
  .clk(clk), .rstn(rstn), .meas(meas), .cfg(cfg),
  .default_colour(default_colour), .relay_coil(relay_coil),
  .status_led(status_led), .display_colour(display_colour));

/* File: logic/acl_cond.sv */
// Set point comparison with hysteresis for one channel
`timescale 1ns/1ns
module acl_cond (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Compared value and channel setup
  input wire logic [acl_pkg::VW-1:0] value,
  input wire acl_pkg::acl_cfg_t cfg,
  // Registered alarm condition
  output logic cond
);
  typedef struct packed {
    logic cond;
  } acl_cond_st_t;

  acl_cond_st_t st;
  acl_cond_st_t next_st;

  // Two extra bits so set point plus or minus a full hysteresis cannot wrap
  function automatic logic signed [acl_pkg::VW+1:0] ext(
    input logic [acl_pkg::VW-1:0] x
  );
    ext = {x[acl_pkg::VW-1], x[acl_pkg::VW-1], x};
  endfunction

  logic signed [acl_pkg::VW+1:0] v;
  logic signed [acl_pkg::VW+1:0] sh;
  logic signed [acl_pkg::VW+1:0] sl;
  logic signed [acl_pkg::VW+1:0] hy;

  always_comb begin
    v = ext(value);
    sh = ext(cfg.set_h);
    sl = ext(cfg.set_l);
    hy = $signed({2'b00, cfg.hyst});
    next_st = st;
    case (cfg.mode) // R13
      acl_pkg::ACL_MODE_HIGH, acl_pkg::ACL_MODE_ONE_SHOT_HIGH: begin
        if (v >= sh) begin // R15
          next_st.cond = 1'b1;
        end else if (v < sh - hy) begin // R4 R5
          next_st.cond = 1'b0;
        end
      end
      acl_pkg::ACL_MODE_LOW, acl_pkg::ACL_MODE_ONE_SHOT_LOW: begin
        if (v < sh) begin
          next_st.cond = 1'b1;
        end else if (v >= sh + hy) begin // R4
          next_st.cond = 1'b0;
        end
      end
      acl_pkg::ACL_MODE_PUMP_HIGH: begin
        if (v >= sh) begin
          next_st.cond = 1'b1;
        end else if (v < sl) begin
          next_st.cond = 1'b0;
        end
      end
      acl_pkg::ACL_MODE_PUMP_LOW: begin
        if (v <= sl) begin
          next_st.cond = 1'b1;
        end else if (v >= sh) begin
          next_st.cond = 1'b0;
        end
      end
      acl_pkg::ACL_MODE_IN_BAND: begin
        next_st.cond = (v >= sl) && (v <= sh);
      end
      acl_pkg::ACL_MODE_OUT_BAND: begin
        next_st.cond = (v < sl) || (v > sh);
      end
      default: begin
        next_st.cond = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cond = st.cond;
endmodule

/* File: logic/acl_pkg.sv */
// Shared types and constants for the alarm channel output logic
package acl_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned TICK_MS = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int NCH = 4;
  localparam int NSRC = 4;
  localparam int VW = 16;
  localparam int TW = 10;
  localparam int SW = 2;
  localparam logic [TW-1:0] TIMER_ZERO = 10'h000;
  localparam logic [TW:0] TIMER_STEP = 11'h001;

  typedef enum logic [2:0] {
    ACL_MODE_HIGH = 3'h0,
    ACL_MODE_LOW = 3'h1,
    ACL_MODE_PUMP_HIGH = 3'h2,
    ACL_MODE_PUMP_LOW = 3'h3,
    ACL_MODE_IN_BAND = 3'h4,
    ACL_MODE_OUT_BAND = 3'h5,
    ACL_MODE_ONE_SHOT_HIGH = 3'h6,
    ACL_MODE_ONE_SHOT_LOW = 3'h7
  } acl_mode_t;

  typedef enum logic [1:0] {
    ACL_COL_OFF = 2'h0,
    ACL_COL_GREEN = 2'h1,
    ACL_COL_RED = 2'h2,
    ACL_COL_YELLOW = 2'h3
  } acl_colour_t;

  typedef enum logic [5:0] {
    ACL_ST_IDLE = 6'h01,
    ACL_ST_ON_WAIT = 6'h02,
    ACL_ST_ACTIVE = 6'h04,
    ACL_ST_PULSE_OFF = 6'h08,
    ACL_ST_OFF_WAIT = 6'h10,
    ACL_ST_SHOT_DONE = 6'h20
  } acl_state_t;

  // Single-limit modes use set_h as the one set point
  typedef struct packed {
    acl_mode_t mode;
    logic [SW-1:0] src;
    logic [VW-1:0] set_h;
    logic [VW-1:0] set_l;
    logic [VW-1:0] hyst;
    logic [TW-1:0] trip_delay;
    logic [TW-1:0] off_delay;
    logic [TW-1:0] pulse;
    logic energise;
    acl_colour_t colour;
  } acl_cfg_t;

  typedef struct packed {
    acl_state_t state;
    logic [TW-1:0] timer;
    logic relay;
    acl_colour_t led;
  } acl_chan_t;
endpackage

/* File: logic/acl_tick.sv */
// Divider that makes the 0.1 s tick enable
`timescale 1ns/1ns
module acl_tick #(
  parameter int unsigned TICK_CYCLES = acl_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Tick enable, one cycle wide
  output logic tick
);
  localparam int CW = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);
  localparam logic [CW-1:0] ONE = CW'(1);

  typedef struct packed {
    logic [CW-1:0] count;
    logic tick;
  } acl_tick_st_t;

  acl_tick_st_t st;
  acl_tick_st_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count == LAST) begin
      next_st.count = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + ONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule

/* File: logic/acl_top.sv */
// Alarm channels: delays, pulsing, relay polarity, LEDs, display colour
`timescale 1ns/1ns
// Operation
// R1 - Highest tripped channel picks display colour (code: highest channel with LED lit, yellow on-delay included)
// R2 - No alarm shows default display colour
// R3 - Per channel relay polarity on alarm
// R4 - Zero hysteresis clears just outside limit
// R5 - High alarm clears below set minus hysteresis
// R6 - Relay trips after continuous on-delay
// R7 - Yellow during on-delay, red when tripped (code: one-shot modes keep the LED off during on-delay)
// R8 - Cycle active pulse, inactive on-delay
// R9 - Cycling LED yellow inactive, red active
// R10 - One-shot modes give one delayed pulse
// R11 - Relay releases after off-delay elapses
// R12 - LED red to off on release
// R13 - Mode selects dual or single set points
// R14 - Per channel measurement source selector
// R15 - High alarm at value at or above
// R16 - LED off when idle
// R17 - One-shot LED red only during pulse
// R18 - Timers count 0.1 s tick, reset idle
// R19 - Zero pulse duration disables cycling
module acl_top #(
  parameter int NCH = acl_pkg::NCH,
  parameter int unsigned TICK_CYCLES = acl_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Measurements and setup
  input wire logic [acl_pkg::NSRC-1:0][acl_pkg::VW-1:0] meas,
  input wire acl_pkg::acl_cfg_t [NCH-1:0] cfg,
  input wire acl_pkg::acl_colour_t default_colour,
  // Relay coils, status LEDs, display colour
  output logic [NCH-1:0] relay_coil,
  output acl_pkg::acl_colour_t [NCH-1:0] status_led,
  output acl_pkg::acl_colour_t display_colour
);
  typedef struct packed {
    acl_pkg::acl_chan_t [NCH-1:0] ch;
    logic [NCH-1:0] coil;
    acl_pkg::acl_colour_t disp;
  } acl_top_st_t;

  acl_top_st_t st;
  acl_top_st_t next_st;
  logic tick;
  logic [NCH-1:0] cond;

  // The first tick after entry may come at once, so it only starts the
  // count; the programmed time then never runs short, at most a tick long
  function automatic logic reached(
    input logic [acl_pkg::TW-1:0] t,
    input logic [acl_pkg::TW-1:0] lim
  );
    reached = t >= lim;
  endfunction

  function automatic logic [acl_pkg::TW-1:0] bump(
    input logic [acl_pkg::TW-1:0] t
  );
    logic [acl_pkg::TW:0] s;
    s = {1'b0, t} + acl_pkg::TIMER_STEP;
    bump = s[acl_pkg::TW-1:0];
  endfunction

  function automatic logic is_shot(input acl_pkg::acl_mode_t m);
    is_shot = (m == acl_pkg::ACL_MODE_ONE_SHOT_HIGH) ||
              (m == acl_pkg::ACL_MODE_ONE_SHOT_LOW);
  endfunction

  acl_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rstn(rstn),
    .tick(tick) // R18
  );

  for (genvar g = 0; g < NCH; g++) begin : gen_cond
    acl_cond u_cond (
      .clk(clk),
      .rstn(rstn),
      .value(meas[cfg[g].src]), // R14
      .cfg(cfg[g]),
      .cond(cond[g])
    );
  end

  always_comb begin
    acl_pkg::acl_chan_t c;
    acl_pkg::acl_cfg_t k;
    logic any;
    c = '0;
    k = '0;
    any = 1'b0;
    next_st = st;
    next_st.disp = default_colour; // R2
    for (int i = 0; i < NCH; i++) begin
      c = st.ch[i];
      k = cfg[i];
      case (c.state)
        acl_pkg::ACL_ST_IDLE: begin
          c.timer = acl_pkg::TIMER_ZERO;
          if (cond[i]) begin
            if (k.trip_delay == acl_pkg::TIMER_ZERO) begin
              c.state = acl_pkg::ACL_ST_ACTIVE;
            end else begin
              c.state = acl_pkg::ACL_ST_ON_WAIT; // R7
            end
          end
        end
        acl_pkg::ACL_ST_ON_WAIT: begin
          // Any dropout restarts the delay from zero
          if (!cond[i]) begin
            c.state = acl_pkg::ACL_ST_IDLE; // R6
          end else if (tick) begin
            if (reached(c.timer, k.trip_delay)) begin
              c.state = acl_pkg::ACL_ST_ACTIVE; // R6 R10
              c.timer = acl_pkg::TIMER_ZERO;
            end else begin
              c.timer = bump(c.timer);
            end
          end
        end
        acl_pkg::ACL_ST_ACTIVE: begin
          if (is_shot(k.mode)) begin
            // The single pulse runs its full length once started
            if (k.pulse == acl_pkg::TIMER_ZERO) begin
              c.state = acl_pkg::ACL_ST_SHOT_DONE;
            end else if (tick) begin
              if (reached(c.timer, k.pulse)) begin
                c.state = acl_pkg::ACL_ST_SHOT_DONE; // R10 R17
                c.timer = acl_pkg::TIMER_ZERO;
              end else begin
                c.timer = bump(c.timer);
              end
            end
          end else if (!cond[i]) begin
            c.timer = acl_pkg::TIMER_ZERO;
            if (k.off_delay == acl_pkg::TIMER_ZERO) begin
              c.state = acl_pkg::ACL_ST_IDLE;
            end else begin
              c.state = acl_pkg::ACL_ST_OFF_WAIT; // R11
            end
          end else if (k.pulse != acl_pkg::TIMER_ZERO && tick) begin // R19
            if (reached(c.timer, k.pulse)) begin
              c.timer = acl_pkg::TIMER_ZERO;
              // With no on-delay the inactive phase is empty
              if (k.trip_delay != acl_pkg::TIMER_ZERO) begin
                c.state = acl_pkg::ACL_ST_PULSE_OFF; // R8
              end
            end else begin
              c.timer = bump(c.timer);
            end
          end
        end
        acl_pkg::ACL_ST_PULSE_OFF: begin
          if (!cond[i]) begin
            c.state = acl_pkg::ACL_ST_IDLE;
            c.timer = acl_pkg::TIMER_ZERO;
          end else if (tick) begin
            if (reached(c.timer, k.trip_delay)) begin
              c.state = acl_pkg::ACL_ST_ACTIVE; // R8
              c.timer = acl_pkg::TIMER_ZERO;
            end else begin
              c.timer = bump(c.timer);
            end
          end
        end
        acl_pkg::ACL_ST_OFF_WAIT: begin
          if (cond[i]) begin
            c.state = acl_pkg::ACL_ST_ACTIVE;
            c.timer = acl_pkg::TIMER_ZERO;
          end else if (tick) begin
            if (reached(c.timer, k.off_delay)) begin
              c.state = acl_pkg::ACL_ST_IDLE; // R11 R12
              c.timer = acl_pkg::TIMER_ZERO;
            end else begin
              c.timer = bump(c.timer);
            end
          end
        end
        acl_pkg::ACL_ST_SHOT_DONE: begin
          // Re-arms only once the condition has gone away
          c.timer = acl_pkg::TIMER_ZERO;
          if (!cond[i]) begin
            c.state = acl_pkg::ACL_ST_IDLE;
          end
        end
        default: begin
          c.state = acl_pkg::ACL_ST_IDLE;
          c.timer = acl_pkg::TIMER_ZERO;
        end
      endcase
      c.relay = (c.state == acl_pkg::ACL_ST_ACTIVE) ||
                (c.state == acl_pkg::ACL_ST_OFF_WAIT);
      case (c.state)
        acl_pkg::ACL_ST_ACTIVE, acl_pkg::ACL_ST_OFF_WAIT: begin
          c.led = acl_pkg::ACL_COL_RED; // R7 R9 R17
        end
        acl_pkg::ACL_ST_ON_WAIT, acl_pkg::ACL_ST_PULSE_OFF: begin
          // One-shot modes stay dark until the pulse itself starts
          if (is_shot(k.mode)) begin
            c.led = acl_pkg::ACL_COL_OFF; // R17
          end else begin
            c.led = acl_pkg::ACL_COL_YELLOW; // R7 R9
          end
        end
        default: begin
          c.led = acl_pkg::ACL_COL_OFF; // R16 R17
        end
      endcase
      // De-energise on alarm keeps the unpowered contact state
      next_st.coil[i] = k.energise ? c.relay : ~c.relay; // R3
      next_st.ch[i] = c;
      if (c.led != acl_pkg::ACL_COL_OFF) begin
        next_st.disp = k.colour; // R1
        any = 1'b1;
      end
    end
    if (!any) begin
      next_st.disp = default_colour; // R2
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st.ch <= '0;
      for (int i = 0; i < NCH; i++) begin
        st.ch[i].state <= acl_pkg::ACL_ST_IDLE; // R18
      end
      // Coils idle de-energised; polarity takes effect one cycle later
      st.coil <= '0;
      st.disp <= acl_pkg::ACL_COL_OFF;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      status_led[i] = st.ch[i].led;
    end
  end

  assign relay_coil = st.coil;
  assign display_colour = st.disp;
endmodule
